//--- hdl/ads_carrier_div.sv
module ads_carrier_div
  import ads_pkg::*;
(
  input  wire logic xtal_clk,
  input  wire logic presetn,
  output logic      carrier,
  output logic      carrier_inverted
);

  logic carrier_q;

  always_ff @(posedge xtal_clk or negedge presetn)
  begin
    if (!presetn)
      carrier_q <= 1'b0;
    else
      carrier_q <= ~carrier_q;
  end

  assign carrier          = carrier_q;
  assign carrier_inverted = ~carrier_q;

endmodule

//--- hdl/ads_pin_sel.sv
module ads_pin_sel
  import ads_pkg::*;
(
  input  wire logic       enable,
  input  wire logic       envelope,
  input  wire logic       force_ask,
  input  wire logic       unmodulated,
  input  wire logic       invert_on,
  input  wire logic       carrier,
  input  wire logic       carrier_inverted,
  input  wire logic [5:0] pmos_steady_value,
  input  wire logic [5:0] pmos_keyed_value,
  input  wire logic [3:0] nmos_steady_value,
  input  wire logic [3:0] nmos_keyed_value,
  output ads_drive_type   drive
);

  logic steady;
  logic phase;

  // Continuous-wave mode only applies when forced ASK is off.
  assign steady = envelope | (unmodulated & ~force_ask);
  assign phase  = invert_on ? carrier_inverted : carrier;

  always_comb
  begin
    // A disabled driver is parked low with keyed conductances.
    drive = '{tx_out: 1'b0, pmos_conductance_sel: pmos_keyed_value, nmos_conductance_sel: nmos_keyed_value};
    if (enable)
    begin
      if (force_ask && !envelope)
        drive.tx_out = 1'b0;
      else
        drive.tx_out = phase;
      drive.pmos_conductance_sel = steady ? pmos_steady_value : pmos_keyed_value;
      drive.nmos_conductance_sel = steady ? nmos_steady_value : nmos_keyed_value;
    end
  end

endmodule

//--- hdl/ads_pkg.sv
package ads_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] ADS_DRIVER_CONTROL_OFFS = 8'h00;
  localparam logic [7:0] ADS_CW_PMOS_OFFS        = 8'h04;
  localparam logic [7:0] ADS_MOD_PMOS_OFFS       = 8'h08;
  localparam logic [7:0] ADS_NMOS_OFFS           = 8'h0c;
  localparam logic [7:0] ADS_FIELD_CFG_OFFS      = 8'h10;
  localparam logic [7:0] ADS_STATUS_OFFS         = 8'h14;
  localparam logic [7:0] ADS_MODEM_OFFS          = 8'h18;

  // Field positions in driver_control.
  localparam int ADS_CTL_A_EN      = 0;
  localparam int ADS_CTL_B_EN      = 1;
  localparam int ADS_CTL_A_INV_OFF = 2;
  localparam int ADS_CTL_A_INV_ON  = 3;
  localparam int ADS_CTL_B_UNMOD   = 4;
  localparam int ADS_CTL_B_INV_OFF = 6;
  localparam int ADS_CTL_B_INV_ON  = 7;
  localparam int ADS_CTL_FULL_ASK  = 8;

  // Field positions in nmos_setting and field_detect_config.
  localparam int ADS_NMOS_MOD_LSB  = 0;
  localparam int ADS_NMOS_CW_LSB   = 4;
  localparam int ADS_FLD_CODE_LSB  = 0;
  localparam int ADS_FLD_AMP       = 4;
  localparam int ADS_FLD_WAKE      = 5;
  localparam int ADS_FLD_IRQ       = 6;

  // Values after reset.
  localparam logic [8:0] ADS_CTL_RESET  = 9'h000;
  localparam logic [5:0] ADS_PMOS_RESET = 6'h3f;
  localparam logic [7:0] ADS_NMOS_RESET = 8'h88;
  localparam logic [6:0] ADS_FLD_RESET  = 7'h00;

  localparam int ADS_FRAME_MAX_BAUD = 848_000;
  localparam int ADS_CARRIER_DIV    = 2;

  typedef struct packed {
    logic       tx_out;
    logic [5:0] pmos_conductance_sel;
    logic [3:0] nmos_conductance_sel;
  } ads_drive_type;

endpackage

//--- hdl/ads_top.sv
// Chosen here: the APB interface to the registers and the register offsets.
module ads_top
  import ads_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        xtal_clk,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        envelope,
  input  wire logic        soft_power_down,
  input  wire logic        field_detected,
  input  wire logic        ext_modem_in,
  input  wire logic        modem_tx_data,
  output logic             ext_modem_out,
  output logic             modem_rx_data,
  output logic             antenna_out_a,
  output logic             antenna_out_b,
  output logic [5:0]       pmos_sel_a,
  output logic [3:0]       nmos_sel_a,
  output logic [5:0]       pmos_sel_b,
  output logic [3:0]       nmos_sel_b,
  output logic [3:0]       field_threshold_code,
  output logic             field_amp_enable,
  output logic             field_wake,
  output logic             field_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // APB register file.

  logic [8:0] driver_control_q;
  logic [5:0] cw_pmos_setting_q;
  logic [5:0] mod_pmos_setting_q;
  logic [7:0] nmos_setting_q;
  logic [6:0] field_detect_config_q;
  logic       modem_bypass_q;
  logic       field_seen_q;
  logic       field_seen_d;
  logic       wr_en;
  logic       rd_en;
  logic       mapped;
  logic [31:0] rdata_d;

  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;

  always_comb
  begin
    mapped  = 1'b1;
    rdata_d = 32'h0000_0000;
    case (paddr)
      ADS_DRIVER_CONTROL_OFFS: rdata_d = {23'h00_0000, driver_control_q};
      ADS_CW_PMOS_OFFS:        rdata_d = {26'h000_0000, cw_pmos_setting_q};
      ADS_MOD_PMOS_OFFS:       rdata_d = {26'h000_0000, mod_pmos_setting_q};
      ADS_NMOS_OFFS:           rdata_d = {24'h00_0000, nmos_setting_q};
      ADS_FIELD_CFG_OFFS:      rdata_d = {25'h000_0000, field_detect_config_q};
      ADS_STATUS_OFFS:         rdata_d = {28'h000_0000, soft_power_down, field_amp_enable, field_detected, field_seen_q};
      ADS_MODEM_OFFS:          rdata_d = {31'h0000_0000, modem_bypass_q};
      default:                 mapped  = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rdata_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      driver_control_q      <= ADS_CTL_RESET;
      cw_pmos_setting_q     <= ADS_PMOS_RESET;
      mod_pmos_setting_q    <= ADS_PMOS_RESET;
      nmos_setting_q        <= ADS_NMOS_RESET;
      field_detect_config_q <= ADS_FLD_RESET;
      modem_bypass_q        <= 1'b0;
    end
    else if (wr_en)
    begin
      case (paddr)
        ADS_DRIVER_CONTROL_OFFS: driver_control_q      <= pwdata[8:0];
        ADS_CW_PMOS_OFFS:        cw_pmos_setting_q     <= pwdata[5:0];
        ADS_MOD_PMOS_OFFS:       mod_pmos_setting_q    <= pwdata[5:0];
        ADS_NMOS_OFFS:           nmos_setting_q        <= pwdata[7:0];
        ADS_FIELD_CFG_OFFS:      field_detect_config_q <= pwdata[6:0];
        ADS_MODEM_OFFS:          modem_bypass_q        <= pwdata[0];
        default:                 modem_bypass_q        <= modem_bypass_q;
      endcase
    end
  end

  // The sticky field flag: a new detection in the clearing cycle wins.
  always_comb
  begin
    field_seen_d = field_seen_q;
    if (rd_en && paddr == ADS_STATUS_OFFS)
      field_seen_d = 1'b0;
    if (field_detected)
      field_seen_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      field_seen_q <= 1'b0;
    else
      field_seen_q <= field_seen_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field detector configuration.

  assign field_threshold_code = field_detect_config_q[ADS_FLD_CODE_LSB +: 4];
  // Power-down overrides the enable so standby current stays low.
  assign field_amp_enable = field_detect_config_q[ADS_FLD_AMP] & ~soft_power_down;
  assign field_wake = field_detected & field_detect_config_q[ADS_FLD_WAKE];
  assign field_irq  = field_seen_q & field_detect_config_q[ADS_FLD_IRQ];

  ////////////////////////////////////////////////////////////////////////////
  // External modem path: framing and checking live in the serial engine
  // beyond this block, so only the raw signal route is provided here.

  assign ext_modem_out = modem_bypass_q ? modem_tx_data : envelope;
  assign modem_rx_data = ext_modem_in;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier and driver selection.

  logic          carrier;
  logic          carrier_inverted;
  logic          tx_env;
  ads_drive_type drive_a;
  ads_drive_type drive_b;

  assign tx_env = modem_bypass_q ? ext_modem_in : envelope;

  ads_carrier_div u_div (
    .xtal_clk         (xtal_clk),
    .presetn          (presetn),
    .carrier          (carrier),
    .carrier_inverted (carrier_inverted)
  );

  // Both pins share one set of conductance registers, so a single enabled
  // driver uses the same values as a pair would.
  ads_pin_sel u_pin_a (
    .enable            (driver_control_q[ADS_CTL_A_EN]),
    .envelope          (tx_env),
    .force_ask         (driver_control_q[ADS_CTL_FULL_ASK]),
    .unmodulated       (1'b0),
    .invert_on         (driver_control_q[ADS_CTL_A_INV_ON]),
    .carrier           (carrier),
    .carrier_inverted  (carrier_inverted),
    .pmos_steady_value (cw_pmos_setting_q),
    .pmos_keyed_value  (mod_pmos_setting_q),
    .nmos_steady_value (nmos_setting_q[ADS_NMOS_CW_LSB +: 4]),
    .nmos_keyed_value  (nmos_setting_q[ADS_NMOS_MOD_LSB +: 4]),
    .drive             (drive_a)
  );

  ads_pin_sel u_pin_b (
    .enable            (driver_control_q[ADS_CTL_B_EN]),
    .envelope          (tx_env),
    .force_ask         (driver_control_q[ADS_CTL_FULL_ASK]),
    .unmodulated       (driver_control_q[ADS_CTL_B_UNMOD]),
    .invert_on         (driver_control_q[ADS_CTL_B_INV_ON]),
    .carrier           (carrier),
    .carrier_inverted  (carrier_inverted),
    .pmos_steady_value (cw_pmos_setting_q),
    .pmos_keyed_value  (mod_pmos_setting_q),
    .nmos_steady_value (nmos_setting_q[ADS_NMOS_CW_LSB +: 4]),
    .nmos_keyed_value  (nmos_setting_q[ADS_NMOS_MOD_LSB +: 4]),
    .drive             (drive_b)
  );

  assign antenna_out_a = drive_a.tx_out;
  assign pmos_sel_a    = drive_a.pmos_conductance_sel;
  assign nmos_sel_a    = drive_a.nmos_conductance_sel;
  assign antenna_out_b = drive_b.tx_out;
  assign pmos_sel_b    = drive_b.pmos_conductance_sel;
  assign nmos_sel_b    = drive_b.nmos_conductance_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // A register access is a setup cycle followed by one access cycle.
  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence ctl_write_s;
    apb_setup_s ##1 (psel && penable && pwrite && paddr == ADS_DRIVER_CONTROL_OFFS);
  endsequence

  sequence status_read_s;
    apb_setup_s ##1 (psel && penable && !pwrite && paddr == ADS_STATUS_OFFS);
  endsequence

  full_ask_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    driver_control_q[ADS_CTL_A_EN] && driver_control_q[ADS_CTL_FULL_ASK] && !tx_env |-> !antenna_out_a)
    else $error("pin A not held low in forced ASK");
  cw_pmos_a: assert property (@(posedge pclk) disable iff (!presetn)
    driver_control_q[ADS_CTL_A_EN] && tx_env |-> pmos_sel_a == cw_pmos_setting_q)
    else $error("pin A steady PMOS wrong");
  mod_pmos_a: assert property (@(posedge pclk) disable iff (!presetn)
    driver_control_q[ADS_CTL_A_EN] && !tx_env |-> pmos_sel_a == mod_pmos_setting_q)
    else $error("pin A keyed PMOS wrong");
  cw_nmos_b_a: assert property (@(posedge pclk) disable iff (!presetn)
    driver_control_q[ADS_CTL_B_EN] && tx_env |-> nmos_sel_b == nmos_setting_q[7:4])
    else $error("pin B steady NMOS wrong");
  mod_nmos_b_a: assert property (@(posedge pclk) disable iff (!presetn)
    driver_control_q[ADS_CTL_B_EN] && !tx_env && !driver_control_q[ADS_CTL_B_UNMOD]
    |-> nmos_sel_b == nmos_setting_q[3:0])
    else $error("pin B keyed NMOS wrong");
  unmod_b_a: assert property (@(posedge pclk) disable iff (!presetn)
    driver_control_q[ADS_CTL_B_EN] && driver_control_q[ADS_CTL_B_UNMOD] && !driver_control_q[ADS_CTL_FULL_ASK]
    |-> pmos_sel_b == cw_pmos_setting_q)
    else $error("pin B unmodulated not steady");
  amp_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    soft_power_down |-> !field_amp_enable)
    else $error("amplifier on in power-down");
  field_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    field_detected && field_detect_config_q[ADS_FLD_IRQ] |=> field_irq)
    else $error("field interrupt missing");
  threshold_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ADS_FIELD_CFG_OFFS |=> field_threshold_code == $past(pwdata[3:0]))
    else $error("threshold not loaded");
  ctl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_write_s |=> driver_control_q == $past(pwdata[8:0]))
    else $error("driver control not loaded");
  status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_read_s |-> prdata[0] == $past(field_seen_q))
    else $error("status read lost the field flag");
  seen_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_read_s ##0 !field_detected |=> !field_seen_q)
    else $error("field flag not cleared by read");
  seen_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    field_detected |=> field_seen_q)
    else $error("field flag not set");
  wake_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    field_detected && field_detect_config_q[ADS_FLD_WAKE] |-> field_wake)
    else $error("field wake missing");
  amp_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    !soft_power_down |-> field_amp_enable == field_detect_config_q[ADS_FLD_AMP])
    else $error("amplifier does not follow its enable");
  b_ask_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    driver_control_q[ADS_CTL_B_EN] && driver_control_q[ADS_CTL_FULL_ASK] && !tx_env |-> !antenna_out_b)
    else $error("pin B not held low in forced ASK");
  a_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
    driver_control_q[ADS_CTL_A_EN] && !(driver_control_q[ADS_CTL_FULL_ASK] && !tx_env)
    |-> antenna_out_a == (driver_control_q[ADS_CTL_A_INV_ON] ? carrier_inverted : carrier))
    else $error("pin A carrier phase wrong");
  b_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
    driver_control_q[ADS_CTL_B_EN] && !(driver_control_q[ADS_CTL_FULL_ASK] && !tx_env)
    |-> antenna_out_b == (driver_control_q[ADS_CTL_B_INV_ON] ? carrier_inverted : carrier))
    else $error("pin B carrier phase wrong");
  b_cw_pmos_a: assert property (@(posedge pclk) disable iff (!presetn)
    driver_control_q[ADS_CTL_B_EN] && tx_env |-> pmos_sel_b == cw_pmos_setting_q)
    else $error("pin B steady PMOS wrong");
  b_mod_pmos_a: assert property (@(posedge pclk) disable iff (!presetn)
    driver_control_q[ADS_CTL_B_EN] && !tx_env && !driver_control_q[ADS_CTL_B_UNMOD]
    |-> pmos_sel_b == mod_pmos_setting_q)
    else $error("pin B keyed PMOS wrong");
  a_cw_nmos_a: assert property (@(posedge pclk) disable iff (!presetn)
    driver_control_q[ADS_CTL_A_EN] && tx_env |-> nmos_sel_a == nmos_setting_q[7:4])
    else $error("pin A steady NMOS wrong");
  a_mod_nmos_a: assert property (@(posedge pclk) disable iff (!presetn)
    driver_control_q[ADS_CTL_A_EN] && !tx_env |-> nmos_sel_a == nmos_setting_q[3:0])
    else $error("pin A keyed NMOS wrong");
  bypass_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    modem_bypass_q |-> ext_modem_out == modem_tx_data)
    else $error("modem output not bypassed");
  bypass_env_a: assert property (@(posedge pclk) disable iff (!presetn)
    modem_bypass_q && driver_control_q[ADS_CTL_A_EN] && ext_modem_in |-> pmos_sel_a == cw_pmos_setting_q)
    else $error("external envelope not used");
  plain_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    !modem_bypass_q |-> ext_modem_out == envelope)
    else $error("modem output not the envelope");

endmodule

//--- tb/ads_far_model.sv
module ads_far_model
(
  input  wire logic pclk,
  input  wire logic env_cmd,
  input  wire logic fld_cmd,
  input  wire logic mdm_cmd,
  output logic      envelope,
  output logic      field_detected,
  output logic      ext_modem_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // The far side changes its levels only just after a pclk edge, like the real modulator.
  initial
  begin
    envelope = 1'b0;
    field_detected = 1'b0;
    ext_modem_in = 1'b0;
  end

  always @(posedge pclk)
  begin
    envelope <= env_cmd;
    field_detected <= fld_cmd;
    ext_modem_in <= mdm_cmd;
  end
endmodule

//--- tb/tb_antenna_driver_select.sv
module tb_antenna_driver_select;
  import ads_pkg::*;
  timeunit 1ns;
  timeprecision 100fs;

  logic        pclk = 1'b0, xtal_clk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, er;
  logic        env_cmd = 1'b0, fld_cmd = 1'b0, mdm_cmd = 1'b0, spd = 1'b0, mtx = 1'b0;
  logic        envelope, field_detected, ext_modem_in, ext_modem_out, modem_rx_data;
  logic        ant_a, ant_b, amp, wake, irq;
  logic [5:0]  psa, psb;
  logic [3:0]  nsa, nsb, thr;
  int          miscompares = 0, total_checks = 0, cycles = 0;
  logic [7:0]  offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [31:0] rstv [5] = '{32'h0000_0000, 32'h0000_003f, 32'h0000_003f, 32'h0000_0088, 32'h0000_0000};

  initial forever #12.5 pclk = ~pclk;
  // The offset keeps crystal edges clear of pclk edges, so pin samples never race a register update.
  initial #3 forever #18.4375 xtal_clk = ~xtal_clk;

  ads_far_model far (.pclk(pclk), .env_cmd(env_cmd), .fld_cmd(fld_cmd), .mdm_cmd(mdm_cmd),
    .envelope(envelope), .field_detected(field_detected), .ext_modem_in(ext_modem_in));

  ads_top dut (.pclk(pclk), .presetn(presetn), .xtal_clk(xtal_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .envelope(envelope), .soft_power_down(spd), .field_detected(field_detected),
    .ext_modem_in(ext_modem_in), .modem_tx_data(mtx), .ext_modem_out(ext_modem_out),
    .modem_rx_data(modem_rx_data), .antenna_out_a(ant_a), .antenna_out_b(ant_b),
    .pmos_sel_a(psa), .nmos_sel_a(nsa), .pmos_sel_b(psb), .nmos_sel_b(nsb),
    .field_threshold_code(thr), .field_amp_enable(amp), .field_wake(wake), .field_irq(irq));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // Pin B against pin A, and pin A toggling at every crystal cycle.
  task automatic rf_rel(input logic inv);
    logic pa;
    repeat (3)
    begin
      @(negedge xtal_clk);
      pa = ant_a;
      check("antenna_out_b", 32'(ant_b), 32'(pa ^ inv));
      @(negedge xtal_clk);
      check("antenna_out_a", 32'(ant_a), 32'(!pa));
    end
  endtask

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, offs[i], 32'h0000_0000);
      check("reset value", rd, rstv[i]);
    end
    apb(1'b0, 8'h1c, 32'h0000_0000);
    check("unmapped read", {rd[30:0], er}, 32'h0000_0001);
    check("pready", 32'(pready), 32'h0000_0001);
    apb(1'b1, ADS_CW_PMOS_OFFS, 32'h0000_0015);
    apb(1'b1, ADS_MOD_PMOS_OFFS, 32'h0000_002a);
    apb(1'b1, ADS_NMOS_OFFS, 32'h0000_003c);
    apb(1'b1, ADS_DRIVER_CONTROL_OFFS, 32'h0000_0001);
    env_cmd <= 1'b1;
    tick(2);
    check("cw sel a", {psa, nsa}, 32'h0000_0153);
    env_cmd <= 1'b0;
    tick(2);
    check("mod sel a", {psa, nsa}, 32'h0000_02ac);
    apb(1'b1, ADS_DRIVER_CONTROL_OFFS, 32'h0000_0003);
    env_cmd <= 1'b1;
    tick(2);
    check("cw sel b", {psb, nsb}, 32'h0000_0153);
    rf_rel(1'b0);
    apb(1'b1, ADS_DRIVER_CONTROL_OFFS, 32'h0000_0083);
    rf_rel(1'b1);
    apb(1'b1, ADS_DRIVER_CONTROL_OFFS, 32'h0000_0093);
    env_cmd <= 1'b0;
    tick(2);
    check("unmod sel b", {psb, nsb, psa}, 32'h0000_54ea);
    rf_rel(1'b1);
    apb(1'b1, ADS_DRIVER_CONTROL_OFFS, 32'h0000_018b);
    repeat (4)
    begin
      @(negedge xtal_clk);
      check("ask low", {ant_a, ant_b}, 32'h0000_0000);
    end
    env_cmd <= 1'b1;
    tick(2);
    rf_rel(1'b0);
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, ADS_FIELD_CFG_OFFS, 32'(c));
      tick(0);
      check("threshold", 32'(thr), 32'(c));
    end
    apb(1'b1, ADS_FIELD_CFG_OFFS, 32'h0000_001c);
    tick(1);
    check("amp on", 32'(amp), 32'h0000_0001);
    spd <= 1'b1;
    tick(1);
    check("amp in power-down", 32'(amp), 32'h0000_0000);
    spd <= 1'b0;
    apb(1'b1, ADS_FIELD_CFG_OFFS, 32'h0000_0060);
    fld_cmd <= 1'b1;
    tick(2);
    check("wake irq", {wake, irq}, 32'h0000_0003);
    fld_cmd <= 1'b0;
    apb(1'b0, ADS_STATUS_OFFS, 32'h0000_0000);
    check("sticky seen", rd, 32'h0000_0001);
    apb(1'b0, ADS_STATUS_OFFS, 32'h0000_0000);
    check("sticky cleared", {rd[30:0], irq}, 32'h0000_0000);
    apb(1'b1, ADS_DRIVER_CONTROL_OFFS, 32'h0000_0001);
    apb(1'b1, ADS_MODEM_OFFS, 32'h0000_0001);
    env_cmd <= 1'b0;
    mdm_cmd <= 1'b1;
    mtx <= 1'b1;
    tick(2);
    check("modem bypass", {ext_modem_out, modem_rx_data, psa}, 32'h0000_00d5);
    apb(1'b1, ADS_MODEM_OFFS, 32'h0000_0000);
    tick(1);
    check("modem out", {ext_modem_out, psa}, 32'h0000_002a);
    tally_and_finish();
  end
endmodule
